// File: hw/output_forced_on_override.sv
`timescale 1ns/1ns
module output_forced_on_override #(
  parameter int unsigned TICK_CYCLES = override_pkg::TICK_CYCLES,
  parameter int unsigned STAIR_MS = override_pkg::STAIR_TIME_MS
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic time_fn_en,
  input wire logic stair_en,
  input wire logic sw_wr,
  input wire logic sw_val,
  input wire logic force_wr,
  input wire logic force_val,
  output logic out_on,
  output logic forced_active
);
  import override_pkg::*;

  // =====================================================================
  // state
  // =====================================================================
  typedef struct packed {
    mode_e mode;
    logic out;
  } core_s;

  core_s st_q;
  core_s st_d;
  logic bg_state;

  bg_if bg ();

  // =====================================================================
  // background functions
  // =====================================================================
  // switch telegrams always reach the background logic, forced or not
  assign bg.sw_wr = sw_wr;
  assign bg.sw_val = sw_val;
  assign bg.stair_en = stair_en;
  assign bg_state = bg.state;

  bg_funcs #(
    .TICK_CYCLES(TICK_CYCLES),
    .STAIR_MS(STAIR_MS)
  ) u_bg (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .bg(bg)
  );

  // =====================================================================
  // override control
  // =====================================================================
  always_comb begin
    st_d = st_q;
    case (st_q.mode)
      MODE_NORMAL: begin
        if (time_fn_en && force_wr && force_val) begin
          st_d.mode = MODE_FORCED;
        end
      end
      MODE_FORCED: begin
        if (force_wr && !force_val) begin
          st_d.mode = MODE_NORMAL;
        end
      end
      default: begin
        st_d.mode = MODE_NORMAL;
      end
    endcase
    // without the time function the object does not exist
    if (!time_fn_en) begin
      st_d.mode = MODE_NORMAL;
    end
    // forced wins over everything; otherwise the shadow state is applied,
    // so release lands on what the background functions reached
    if (st_d.mode == MODE_FORCED) begin
      st_d.out = 1'b1;
    end else begin
      st_d.out = bg_state;
    end
  end

  // =====================================================================
  // state register
  // =====================================================================
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= '{mode: MODE_NORMAL, out: OUT_RST};
    end else begin
      st_q <= st_d;
    end
  end

  assign out_on = st_q.out;
  assign forced_active = (st_q.mode == MODE_FORCED);

  // =====================================================================
  // checks
  // =====================================================================
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // helper: a release telegram in this cycle
  logic release_req;
  assign release_req = force_wr && !force_val;

  // helper: counts cycles spent forced, for a long-hold check
  logic [7:0] forced_cnt;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      forced_cnt <= 8'h00;
    end else if (!forced_active) begin
      forced_cnt <= 8'h00;
    end else if (forced_cnt != 8'hFF) begin
      forced_cnt <= forced_cnt + 8'h01;
    end
  end

  // object ignored while the time function is off
  no_time_gate_a: assert property (
    !time_fn_en |=> !forced_active && out_on == $past(bg_state)
  ) else $error("forced-on acted with time function disabled");

  // a forced-on one gives output on at the next edge
  force_on_a: assert property (
    time_fn_en && force_wr && force_val |=> forced_active && out_on
  ) else $error("forced-on one did not switch output on");

  // with the time function on, forced state holds until a zero arrives
  hold_forced_a: assert property (
    forced_active && time_fn_en && !release_req
      |=> forced_active [*1] ##0 out_on
  ) else $error("override ended without a zero telegram");

  // in normal mode output tracks the background state one cycle later
  normal_follow_a: assert property (
    !forced_active ##1 !forced_active |-> out_on == $past(bg_state)
  ) else $error("output does not follow switch state");

  // switch telegrams cannot drop the output while forced; only a release
  // or a disabled time function in the next cycle may let it fall after
  mask_other_a: assert property (
    forced_active && sw_wr && !sw_val && !release_req && time_fn_en
      |=> out_on ##1 (out_on || $past(release_req || !time_fn_en))
  ) else $error("switch telegram changed forced output");

  // staircase start while forced shows in the shadow state
  bg_running_a: assert property (
    forced_active && stair_en && sw_wr && sw_val |=> bg_state
  ) else $error("background function frozen by override");

  // release applies the shadow state at once
  resume_state_a: assert property (
    $fell(forced_active) |-> out_on == $past(bg_state)
  ) else $error("release did not apply background state");

  // long override keeps the output on; the counter clears a cycle after
  // release, so the mode itself gates the check
  long_hold_a: assert property (
    forced_active && forced_cnt >= 8'h20 |-> out_on
  ) else $error("output dropped during long override");

  force_release_c: cover property (
    force_wr && force_val && time_fn_en ##[1:20] $fell(forced_active)
  );
  release_to_off_c: cover property (
    $fell(forced_active) && !out_on
  );
  switch_while_forced_c: cover property (
    forced_active && sw_wr && !sw_val
  );
  stair_expiry_forced_c: cover property (
    forced_active && $fell(bg_state)
  );

endmodule

// File: shared/override_pkg.sv
package override_pkg;

  // =====================================================================
  // clock and timing
  // =====================================================================
  // system clock period in ns (250 MHz)
  localparam int unsigned CLK_PERIOD_NS = 4;
  // staircase time base: one tick per millisecond
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  // cycles per tick, a longest time so it rounds down, never below one
  localparam int unsigned TICK_CYCLES =
    (TICK_PERIOD_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (TICK_PERIOD_NS / CLK_PERIOD_NS);
  // staircase on time in ms
  localparam int unsigned STAIR_TIME_MS = 60000;

  // =====================================================================
  // widths and reset values
  // =====================================================================
  localparam int unsigned CNT_W = 32;
  localparam logic OUT_RST = 1'h0;
  localparam logic SW_RST = 1'h0;

  // =====================================================================
  // override modes
  // =====================================================================
  typedef enum logic {
    MODE_NORMAL,
    MODE_FORCED
  } mode_e;

endpackage

// File: shared/bg_if.sv
`timescale 1ns/1ns
// carries telegrams to the background functions and their result back
interface bg_if;
  logic sw_wr;
  logic sw_val;
  logic stair_en;
  logic state;

  modport core (
    output sw_wr,
    output sw_val,
    output stair_en,
    input state
  );

  modport funcs (
    input sw_wr,
    input sw_val,
    input stair_en,
    output state
  );
endinterface

// File: hw/bg_funcs.sv
`timescale 1ns/1ns
module bg_funcs #(
  parameter int unsigned TICK_CYCLES = override_pkg::TICK_CYCLES,
  parameter int unsigned STAIR_MS = override_pkg::STAIR_TIME_MS
) (
  input wire logic clk_sys,
  input wire logic resetn,
  bg_if.funcs bg
);
  import override_pkg::*;

  typedef struct packed {
    logic sw;
    logic stair;
    logic [CNT_W-1:0] div;
    logic [CNT_W-1:0] ms;
  } bg_s;

  bg_s st_q;
  bg_s st_d;
  logic tick;

  // =====================================================================
  // next state
  // =====================================================================
  // the divider and timer run without regard to any override
  always_comb begin
    st_d = st_q;
    tick = (st_q.div == CNT_W'(TICK_CYCLES - 1));
    st_d.div = tick ? '0 : st_q.div + CNT_W'(1);
    if (st_q.stair && tick) begin
      st_d.ms = st_q.ms - CNT_W'(1);
      if (st_q.ms <= CNT_W'(1)) begin
        st_d.stair = 1'b0; // time up, light would go off
      end
    end
    // a new telegram wins over an expiring timer
    if (bg.sw_wr) begin
      st_d.sw = bg.sw_val;
      if (bg.stair_en) begin
        st_d.stair = bg.sw_val; // on retriggers, off cuts short
        st_d.ms = CNT_W'(STAIR_MS);
      end
    end
    if (!bg.stair_en) begin
      st_d.stair = 1'b0;
    end
  end

  // =====================================================================
  // state register
  // =====================================================================
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= '{sw: SW_RST, stair: 1'b0, div: '0, ms: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // the state the output would have without an override
  assign bg.state = bg.stair_en ? st_q.stair : st_q.sw;

endmodule

// File: tb/tel_src.sv
`timescale 1ns/1ns
// =====================================================================
// telegram source standing in for the installation bus
// =====================================================================
module tel_src (
  input wire logic clk_sys,
  output logic sw_wr,
  output logic sw_val,
  output logic force_wr,
  output logic force_val
);
  // idle: strobes low, values inverted so stale data never looks valid
  initial begin
    sw_wr = 1'h0;
    sw_val = 1'h1;
    force_wr = 1'h0;
    force_val = 1'h1;
  end

  // one switch telegram; returns at the edge that takes it
  task automatic send_sw(input logic v);
    @(posedge clk_sys);
    sw_wr <= 1'h1;
    sw_val <= v;
    @(posedge clk_sys);
    sw_wr <= 1'h0;
    sw_val <= ~v;
  endtask

  // raw traffic for one cycle, bits {force_val, force_wr, sw_val, sw_wr}
  task automatic put(input logic [3:0] b);
    sw_wr <= b[0];
    sw_val <= b[1];
    force_wr <= b[2];
    force_val <= b[3];
  endtask

  // one forced-on telegram; returns at the edge that takes it
  task automatic send_force(input logic v);
    @(posedge clk_sys);
    force_wr <= 1'h1;
    force_val <= v;
    @(posedge clk_sys);
    force_wr <= 1'h0;
    force_val <= ~v;
  endtask
endmodule

// File: tb/output_forced_on_override_tb_top.sv
`timescale 1ns/1ns
module output_forced_on_override_tb_top;
  // short time base so the staircase ends after about 20 cycles
  localparam int unsigned TICKS = 4;
  localparam int unsigned STAIR = 5;
  logic clk_sys = 1'h0;
  logic resetn = 1'h0;
  logic time_fn_en = 1'h0;
  logic stair_en = 1'h0;
  logic sw_wr, sw_val, force_wr, force_val, out_on, forced_active;
  int failures = 0;
  int n_tests = 0;
  logic [1:0] exp_q[$];
  logic [31:0] rnd = 32'hB716;
  logic last_sw = 1'h0;
  // reference model of the random phase: {time_en, force, switch} inputs
  logic [4:0] p_b = 5'h10;
  logic m_sw = 1'h0;
  logic m_forced = 1'h0;
  logic m_out = 1'h0;

  always #2 clk_sys = ~clk_sys;

  output_forced_on_override #(.TICK_CYCLES(TICKS), .STAIR_MS(STAIR))
      output_forced_on_override_i (.clk_sys(clk_sys), .resetn(resetn),
      .time_fn_en(time_fn_en), .stair_en(stair_en), .sw_wr(sw_wr),
      .sw_val(sw_val), .force_wr(force_wr), .force_val(force_val),
      .out_on(out_on), .forced_active(forced_active));
  tel_src tel_src_i (.clk_sys(clk_sys), .sw_wr(sw_wr), .sw_val(sw_val),
      .force_wr(force_wr), .force_val(force_val));

  // =====================================================================
  // helpers
  // =====================================================================
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic steps(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // config changes land by nba on a rising edge
  task automatic cfg(input logic t, input logic s);
    @(posedge clk_sys);
    time_fn_en <= t;
    stair_en <= s;
  endtask

  // note expected {out_on, forced_active}; the watcher compares it
  task automatic expect_st(input logic [1:0] e);
    exp_q.push_back(e);
    @(negedge clk_sys);
  endtask

  // bounded wait for the staircase to switch the output off
  task automatic wait_off();
    int k;
    for (k = 0; k < 60 && out_on !== 1'h0; k++) begin
      @(posedge clk_sys);
    end
    n_tests++;
    if (k == 60) begin
      failures++;
      $display("mismatch at %0t: output never went off", $time);
    end
  endtask

  // watcher: compares settled outputs mid-cycle with the oldest note
  always @(negedge clk_sys) begin
    if (exp_q.size() > 0) begin
      n_tests++;
      if ({out_on, forced_active} !== exp_q[0]) begin
        failures++;
        $display("mismatch at %0t: got %b expected %b", $time,
                 {out_on, forced_active}, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
  end

  // =====================================================================
  // main sequence
  // =====================================================================
  initial begin
    steps(4);
    resetn <= 1'h1;
    steps(1);
    // object absent while the time function is disabled
    tel_src_i.send_force(1'h1);
    steps(1);
    expect_st(2'h0);
    cfg(1'h1, 1'h0);
    // force, random switch traffic underneath, then release
    repeat (4) begin
      tel_src_i.send_force(1'h1);
      steps(1);
      expect_st(2'h3);
      repeat (3) begin
        rnd = lfsr(rnd);
        last_sw = rnd[0];
        tel_src_i.send_sw(last_sw);
        steps(2);
        expect_st(2'h3);
      end
      tel_src_i.send_force(1'h1);
      steps(1);
      expect_st(2'h3);
      tel_src_i.send_force(1'h0);
      steps(1);
      expect_st({last_sw, 1'h0});
    end
    // staircase times out in the background while forced
    cfg(1'h1, 1'h1);
    tel_src_i.send_sw(1'h0);
    tel_src_i.send_force(1'h1);
    tel_src_i.send_sw(1'h1);
    steps(40);
    expect_st(2'h3);
    tel_src_i.send_force(1'h0);
    steps(1);
    expect_st(2'h0);
    // release while the background staircase still runs
    tel_src_i.send_force(1'h1);
    tel_src_i.send_sw(1'h1);
    steps(4);
    tel_src_i.send_force(1'h0);
    steps(1);
    expect_st(2'h2);
    wait_off();
    // random traffic on every object, time function toggling too
    cfg(1'h1, 1'h0);
    tel_src_i.send_sw(1'h0);
    steps(2);
    for (int i = 0; i < 200; i++) begin
      @(posedge clk_sys);
      // the model takes what the design took at this edge
      if (!p_b[4]) begin
        m_forced = 1'h0;
      end else if (p_b[2]) begin
        m_forced = p_b[3];
      end
      m_out = m_forced | m_sw;
      if (p_b[0]) begin
        m_sw = p_b[1];
      end
      exp_q.push_back({m_out, m_forced});
      rnd = lfsr(rnd);
      p_b = {rnd[4] | rnd[5], rnd[3:0]};
      time_fn_en <= p_b[4];
      tel_src_i.put(p_b[3:0]);
    end
    @(posedge clk_sys);
    time_fn_en <= 1'h1;
    tel_src_i.put(4'h0);
    steps(2);
    report_and_stop();
  end
endmodule
